/* asp_pkg.sv */
package asp_pkg;
  // register frame: eleven byte-wide registers on the 16-bit peripheral bus
  localparam logic [15:0] ASP_BASE = 16'h7050;
  localparam logic [15:0] ASP_NUM_REGS = 16'h000B;
  localparam logic [3:0] REG_CHAR_CTL = 4'h0;
  localparam logic [3:0] REG_CTL1 = 4'h1;
  localparam logic [3:0] REG_BAUD_HI = 4'h2;
  localparam logic [3:0] REG_BAUD_LO = 4'h3;
  localparam logic [3:0] REG_CTL2 = 4'h4;
  localparam logic [3:0] REG_RX_STAT = 4'h5;
  localparam logic [3:0] REG_RX_PEEK = 4'h6;
  localparam logic [3:0] REG_RX_BUF = 4'h7;
  localparam logic [3:0] REG_TX_BUF = 4'h9;
  localparam logic [3:0] REG_PIN_CTL = 4'hA;
  // character control fields
  localparam int CC_STOP2 = 7;
  localparam int CC_PAR_ODD = 6;
  localparam int CC_PAR_EN = 5;
  localparam int CC_ADDR_MODE = 3;
  localparam int CC_LEN_LSB = 0;
  localparam int CC_LEN_W = 3;
  // control 1 fields
  localparam int C1_RXERR_IE = 6;
  localparam int C1_TXWAKE = 3;
  localparam int C1_SLEEP = 2;
  localparam int C1_TX_EN = 1;
  localparam int C1_RX_EN = 0;
  // control 2 fields
  localparam int C2_TX_BUFFER_READY_FLAG = 7;
  localparam int C2_TXEMPTY = 6;
  localparam int C2_RX_IE = 1;
  localparam int C2_TX_IE = 0;
  // receive status fields
  localparam int RS_ERROR = 7;
  localparam int RS_RX_BUFFER_READY_FLAG = 6;
  localparam int RS_BREAK = 5;
  localparam int RS_FRAME = 4;
  localparam int RS_OVERRUN = 3;
  localparam int RS_PARITY = 2;
  localparam int RS_WAKE = 1;
  // pin control fields
  localparam int PC_TX_FUNC = 0;
  localparam int PC_RX_FUNC = 1;
  localparam int PC_TX_DIR = 2;
  localparam int PC_TX_OUT = 3;
  localparam int PC_RX_DIR = 4;
  localparam int PC_RX_OUT = 5;
  localparam int PC_TX_IN = 6;
  localparam int PC_RX_IN = 7;
  // reset values
  localparam logic [7:0] CHAR_CTL_RST = 8'h07;
  localparam logic [7:0] CTL1_RST = 8'h00;
  localparam logic [7:0] CTL2_RST = 8'h00;
  localparam logic [15:0] BAUD_RST = 16'h0000;
  localparam logic [7:0] PIN_CTL_RST = 8'h03;
  // timing
  localparam int CLK_HZ = 20_000_000;
  localparam logic [2:0] OVS_LAST = 3'h7;
  localparam logic [2:0] START_MID = 3'h3;
  localparam logic [6:0] IDLE_TICKS = 7'h50;
  localparam logic [3:0] WAKE_GAP_BITS = 4'hB;
  localparam logic [3:0] MAX_FRAME_BITS = 4'hD;
endpackage

`timescale 1ns/100ps
`default_nettype none

// oversample tick generator: one pulse every divisor+1 clocks
module asp_baud_gen #(
  parameter int DIV_W = 16
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [DIV_W-1:0] divisor,
  output logic tick
);
  logic [DIV_W-1:0] count;
  logic [DIV_W-1:0] limit;

  // zero is clamped to one so the period never falls below two clocks
  assign limit = (divisor == '0) ? DIV_W'(1) : divisor;

  // up counter compares against the live divisor and clears to zero at the limit
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      count <= '0;
      tick <= 1'b0;
    end else if (count >= limit) begin
      count <= '0;
      tick <= 1'b1;
    end else begin
      count <= count + DIV_W'(1);
      tick <= 1'b0;
    end
  end
endmodule

`default_nettype wire

/* asp_serial_port.sv */
// Contract
// RQ1: frames are NRZ on the line with one start bit before data.
// RQ2: character length programmable from one to eight bits, both directions.
// RQ3: optional parity after data, even or odd, sent and checked.
// RQ4: frame ends with one or two stop bits, software chosen.
// RQ5: bit period comes from a 16-bit software baud divisor.
// RQ6: fastest setting gives 625 kbit/s from a 10 MHz system clock.
// RQ7: parity, overrun, framing and break each have their own flag.
// RQ8: separate function and interrupt enables for transmitter and receiver.
// RQ9: half-duplex as well as full-duplex use of the link.
// RQ10: transmit and receive each buffered ahead of the shift register.
// RQ11: idle-line and address-bit multiprocessor wake-up schemes.
// RQ12: transmit-ready set while the transmit buffer can take a character.
// RQ13: transmitter-empty set while the shift register has nothing left.
// RQ14: receive-ready shows a character waiting in the receive buffer.
// RQ15: break-detect set when a break is seen on the receive line.
// RQ16: summary error flag set while any receive error is present.
// RQ17: each interrupt gated by its own enable; break bypasses enables.
// RQ18: both pins usable as serial pins or general-purpose I/O.
// RQ19: eleven registers starting at peripheral address 7050h.
// RQ20: 8-bit registers on bits 7-0; upper byte reads zero, writes ignored.
// RQ21: line idles high, start low, stop high, data LSB first.
// RQ22: receiver samples bit centres from start edge; low stop is framing.
`timescale 1ns/100ps
`default_nettype none

module asp_serial_port
  import asp_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [15:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [15:0] bus_rdata,
  input wire logic serial_tx_pin_i,
  output logic serial_tx_pin_o,
  output logic serial_tx_pin_oe,
  input wire logic serial_rx_pin_i,
  output logic serial_rx_pin_o,
  output logic serial_rx_pin_oe,
  output logic tx_int,
  output logic rx_int
);
  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_GAP = 3'b010,
    TX_SHIFT = 3'b100
  } asp_tx_state_type;

  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA = 4'b0100,
    RX_STOP = 4'b1000
  } asp_rx_state_type;

  logic [7:0] char_ctl;
  logic [7:0] ctl1;
  logic [7:0] ctl2;
  logic [15:0] baud_div;
  logic [7:0] pin_ctl;
  logic [15:0] offset;
  logic hit;
  logic [3:0] idx;
  logic wr_hit;
  logic rd_hit;
  logic tick;
  logic [2:0] len_m1;

  // decode: whole frame is 16-aligned, so the low nibble is the index
  assign offset = bus_addr - ASP_BASE;
  assign hit = offset < ASP_NUM_REGS; // [RQ19]
  assign idx = offset[3:0];
  assign wr_hit = bus_wr && hit;
  assign rd_hit = bus_rd && hit;
  assign len_m1 = char_ctl[CC_LEN_LSB +: CC_LEN_W];

  // control registers, low byte only
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      char_ctl <= CHAR_CTL_RST;
      ctl2 <= CTL2_RST;
      baud_div <= BAUD_RST;
      pin_ctl <= PIN_CTL_RST;
    end else if (wr_hit) begin
      case (idx)
        REG_CHAR_CTL: char_ctl <= bus_wdata[7:0]; // [RQ20]
        REG_CTL2: ctl2 <= bus_wdata[7:0];
        REG_BAUD_HI: baud_div[15:8] <= bus_wdata[7:0]; // [RQ5]
        REG_BAUD_LO: baud_div[7:0] <= bus_wdata[7:0];
        REG_PIN_CTL: pin_ctl <= bus_wdata[7:0];
        default: ;
      endcase
    end
  end

  // divisor d gives 8*(d+1) clocks a bit; d=1 at 10 MHz is 625 kbit/s
  asp_baud_gen #(
    .DIV_W(16)
  ) u_baud (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .divisor(baud_div),
    .tick(tick)
  ); // [RQ5] [RQ6]

  // ---------------- pins ----------------
  logic tx_line;
  logic rx_line;

  // each pin either carries the serial function or is a plain port bit
  assign serial_tx_pin_o = pin_ctl[PC_TX_FUNC] ? tx_line
                                               : pin_ctl[PC_TX_OUT]; // [RQ18]
  assign serial_tx_pin_oe = pin_ctl[PC_TX_FUNC] | pin_ctl[PC_TX_DIR];
  assign serial_rx_pin_o = pin_ctl[PC_RX_OUT]; // [RQ18]
  assign serial_rx_pin_oe = ~pin_ctl[PC_RX_FUNC] & pin_ctl[PC_RX_DIR];
  // a pin taken for I/O looks like an idle line to the receiver
  assign rx_line = pin_ctl[PC_RX_FUNC] ? serial_rx_pin_i : 1'b1;

  // ---------------- transmitter ----------------
  asp_tx_state_type tx_state;
  logic [7:0] tx_buf;
  logic tx_buf_full;
  logic [12:0] tx_frame;
  logic [12:0] next_tx_frame;
  logic [3:0] next_tx_count;
  logic [3:0] tx_left;
  logic [2:0] tx_phase;
  logic tx_load;
  logic tx_bit_end;
  logic tx_buf_wr;

  assign tx_buf_wr = wr_hit && (idx == REG_TX_BUF);
  assign tx_load = (tx_state == TX_IDLE) && tx_buf_full && ctl1[C1_TX_EN];
  assign tx_bit_end = tick && (tx_phase == OVS_LAST);

  // assemble start, data, address, parity and stop bits, LSB first
  always_comb begin
    logic [3:0] pos;
    logic par;
    pos = 4'h1;
    par = char_ctl[CC_PAR_ODD];
    next_tx_frame = '1; // stop bits and idle are high [RQ21]
    next_tx_frame[0] = 1'b0; // start bit [RQ1]
    for (int i = 0; i < 8; i++) begin
      if (3'(i) <= len_m1) begin
        next_tx_frame[pos] = tx_buf[i]; // [RQ2]
        par = par ^ tx_buf[i];
        pos = pos + 4'h1;
      end
    end
    if (char_ctl[CC_ADDR_MODE]) begin
      next_tx_frame[pos] = ctl1[C1_TXWAKE]; // address bit [RQ11]
      par = par ^ ctl1[C1_TXWAKE];
      pos = pos + 4'h1;
    end
    if (char_ctl[CC_PAR_EN]) begin
      next_tx_frame[pos] = par; // [RQ3]
      pos = pos + 4'h1;
    end
    next_tx_count = pos + (char_ctl[CC_STOP2] ? 4'h2 : 4'h1); // [RQ4]
  end

  // transmit buffer register ahead of the shifter
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tx_buf <= 8'h00;
      tx_buf_full <= 1'b0;
    end else if (tx_buf_wr) begin
      tx_buf <= bus_wdata[7:0]; // [RQ10]
      tx_buf_full <= 1'b1;
    end else if (tx_load) begin
      tx_buf_full <= 1'b0;
    end
  end

  // shifter; disabling the transmitter drops the frame, line goes high
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tx_state <= TX_IDLE;
      tx_frame <= '1;
      tx_left <= 4'h0;
      tx_phase <= 3'h0;
    end else if (!ctl1[C1_TX_EN]) begin
      tx_state <= TX_IDLE; // [RQ8]
      tx_frame <= '1;
      tx_left <= 4'h0;
    end else begin
      if (tick) begin
        tx_phase <= tx_phase + 3'h1;
      end
      case (tx_state)
        TX_IDLE: begin
          if (tx_load) begin
            tx_frame <= next_tx_frame;
            tx_phase <= 3'h0;
            // idle-line wake marks a block with a long high gap first
            if (!char_ctl[CC_ADDR_MODE] && ctl1[C1_TXWAKE]) begin
              tx_state <= TX_GAP; // [RQ11]
              tx_left <= WAKE_GAP_BITS;
            end else begin
              tx_state <= TX_SHIFT;
              tx_left <= next_tx_count;
            end
          end
        end
        TX_GAP: begin
          if (tx_bit_end) begin
            if (tx_left == 4'h1) begin
              tx_state <= TX_SHIFT;
              tx_left <= next_tx_count;
            end else begin
              tx_left <= tx_left - 4'h1;
            end
          end
        end
        TX_SHIFT: begin
          if (tx_bit_end) begin
            tx_frame <= {1'b1, tx_frame[12:1]}; // LSB first [RQ21]
            tx_left <= tx_left - 4'h1;
            if (tx_left == 4'h1) begin
              tx_state <= TX_IDLE;
            end
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  // gated by the enable so a disable takes the line high at once
  assign tx_line = (tx_state == TX_SHIFT && ctl1[C1_TX_EN]) ? tx_frame[0]
                                                           : 1'b1; // [RQ1]

  // ---------------- receiver ----------------
  asp_rx_state_type rx_state;
  logic [9:0] rx_shift;
  logic [3:0] rx_cnt;
  logic [3:0] rx_nbits;
  logic [2:0] rx_phase;
  logic [6:0] idle_cnt;
  logic after_idle;
  logic [7:0] rx_buf;
  logic rx_rdy;
  logic rx_pe;
  logic rx_oe;
  logic rx_fe;
  logic rx_brk;
  logic rx_wake;
  logic rx_done;
  logic rx_stop_bit;
  logic [7:0] rx_data;
  logic rx_addr_bit;
  logic rx_par_bit;
  logic rx_par_err;
  logic rx_is_addr;
  logic rx_accept;
  logic rx_buf_rd;
  logic rx_err;
  logic rx_line_q;

  assign rx_nbits = {1'b0, len_m1} + 4'h1 + {3'h0, char_ctl[CC_ADDR_MODE]}
                    + {3'h0, char_ctl[CC_PAR_EN]};

  // unpack the sampled bits of the finished character
  always_comb begin
    rx_data = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (3'(i) <= len_m1) begin
        rx_data[i] = rx_shift[i]; // [RQ2]
      end
    end
    rx_addr_bit = rx_shift[{1'b0, len_m1} + 4'h1];
    rx_par_bit = rx_shift[rx_nbits - 4'h1];
    rx_par_err = char_ctl[CC_PAR_EN] && ((^rx_data) ^ rx_par_bit
                 ^ (char_ctl[CC_ADDR_MODE] & rx_addr_bit)
                 ^ char_ctl[CC_PAR_ODD]); // [RQ3]
  end

  assign rx_done = (rx_state == RX_STOP) && tick && (rx_phase == OVS_LAST);
  assign rx_stop_bit = rx_line;
  assign rx_is_addr = char_ctl[CC_ADDR_MODE] ? rx_addr_bit : after_idle;
  // asleep, only address characters and breaks reach the buffer
  assign rx_accept = rx_done && (!ctl1[C1_SLEEP] || rx_is_addr
                     || (rx_shift == 10'h000 && !rx_stop_bit)); // [RQ11]
  assign rx_buf_rd = rd_hit && (idx == REG_RX_BUF);

  // previous line level; resets to idle high so reset makes no false edge
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rx_line_q <= 1'b1;
    end else begin
      rx_line_q <= rx_line;
    end
  end

  // start detect, centre sampling, stop check
  always_ff @(posedge core_clk) begin
    if (sys_rst || !ctl1[C1_RX_EN]) begin
      rx_state <= RX_IDLE; // [RQ8]
      rx_shift <= 10'h000;
      rx_cnt <= 4'h0;
      rx_phase <= 3'h0;
    end else begin
      if (tick) begin
        rx_phase <= rx_phase + 3'h1;
      end
      case (rx_state)
        RX_IDLE: begin
          // falling edge only: a line still low after a bad stop is no start
          if (rx_line_q && !rx_line) begin // [RQ22]
            rx_state <= RX_START;
            rx_phase <= 3'h0;
            rx_shift <= 10'h000;
          end
        end
        RX_START: begin
          // recheck half a bit in, a short glitch is not a start
          if (tick && rx_phase == START_MID) begin
            rx_phase <= 3'h0;
            rx_cnt <= 4'h0;
            rx_state <= rx_line ? RX_IDLE : RX_DATA; // [RQ22]
          end
        end
        RX_DATA: begin
          if (tick && rx_phase == OVS_LAST) begin
            rx_shift[rx_cnt] <= rx_line; // [RQ22]
            rx_cnt <= rx_cnt + 4'h1;
            if (rx_cnt == rx_nbits - 4'h1) begin
              rx_state <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          // only the first stop bit is checked, a second is just idle
          if (rx_done) begin
            rx_state <= RX_IDLE;
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // idle-line detector: ten bit times of high between characters
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      idle_cnt <= 7'h00;
      after_idle <= 1'b0;
    end else if (rx_state != RX_IDLE || !rx_line) begin
      idle_cnt <= 7'h00;
      if (rx_state == RX_IDLE) begin
        after_idle <= (idle_cnt == IDLE_TICKS); // [RQ11]
      end
    end else if (tick && idle_cnt != IDLE_TICKS) begin
      idle_cnt <= idle_cnt + 7'h01;
    end
  end

  // receive buffer and flags; a new character wins over a buffer read
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rx_buf <= 8'h00;
      rx_rdy <= 1'b0;
      rx_pe <= 1'b0;
      rx_oe <= 1'b0;
      rx_fe <= 1'b0;
      rx_brk <= 1'b0;
      rx_wake <= 1'b0;
    end else begin
      if (rx_buf_rd) begin
        rx_rdy <= 1'b0; // [RQ14]
        rx_pe <= 1'b0;
        rx_oe <= 1'b0;
        rx_fe <= 1'b0;
        rx_brk <= 1'b0;
      end
      if (rx_accept) begin
        rx_buf <= rx_data; // [RQ10]
        rx_rdy <= 1'b1; // [RQ14]
        rx_wake <= rx_is_addr;
        rx_pe <= rx_par_err; // [RQ7]
        rx_fe <= !rx_stop_bit; // [RQ22]
        // unread character still waiting means the old one is lost
        rx_oe <= rx_rdy && !rx_buf_rd; // [RQ7]
        rx_brk <= (rx_shift == 10'h000) && !rx_stop_bit; // [RQ15]
      end
    end
  end

  assign rx_err = rx_pe | rx_oe | rx_fe | rx_brk; // [RQ16]

  // control 1, software clears wake bit; load clears it too unless rewritten
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctl1 <= CTL1_RST;
    end else if (wr_hit && idx == REG_CTL1) begin
      ctl1 <= bus_wdata[7:0]; // [RQ8] [RQ9]
    end else if (tx_load) begin
      ctl1[C1_TXWAKE] <= 1'b0;
    end
  end

  // interrupt levels; break reaches the receiver line with no enable
  assign tx_int = ctl2[C2_TX_IE] & ~tx_buf_full & ctl1[C1_TX_EN]; // [RQ17]
  assign rx_int = (ctl2[C2_RX_IE] & rx_rdy)
                  | (ctl1[C1_RXERR_IE] & rx_err) | rx_brk; // [RQ17]

  // read data, one cycle after the strobe, upper byte always zero
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      bus_rdata <= 16'h0000;
    end else if (rd_hit) begin
      bus_rdata[15:8] <= 8'h00; // [RQ20]
      case (idx)
        REG_CHAR_CTL: bus_rdata[7:0] <= char_ctl;
        REG_CTL1: bus_rdata[7:0] <= ctl1;
        REG_BAUD_HI: bus_rdata[7:0] <= baud_div[15:8];
        REG_BAUD_LO: bus_rdata[7:0] <= baud_div[7:0];
        REG_CTL2: begin
          bus_rdata[7:0] <= ctl2;
          bus_rdata[C2_TX_BUFFER_READY_FLAG] <= ~tx_buf_full; // [RQ12]
          bus_rdata[C2_TXEMPTY] <= (tx_state == TX_IDLE) && !tx_load; // [RQ13]
        end
        REG_RX_STAT: bus_rdata[7:0] <= {rx_err, rx_rdy, rx_brk, rx_fe,
                                        rx_oe, rx_pe, rx_wake, 1'b0}; // [RQ7]
        REG_RX_PEEK: bus_rdata[7:0] <= rx_buf;
        REG_RX_BUF: bus_rdata[7:0] <= rx_buf;
        REG_PIN_CTL: begin
          bus_rdata[7:0] <= pin_ctl;
          bus_rdata[PC_TX_IN] <= serial_tx_pin_i;
          bus_rdata[PC_RX_IN] <= serial_rx_pin_i;
        end
        default: bus_rdata[7:0] <= 8'h00;
      endcase
    end else begin
      bus_rdata <= 16'h0000;
    end
  end
endmodule

`default_nettype wire

/* asp_serial_port_props.sv */
`timescale 1ns/100ps
`default_nettype none
// port checks against shadow copies of the pin, control 1, control 2 and baud bytes
module asp_serial_port_chk
  import asp_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [15:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [15:0] bus_rdata,
  input wire logic serial_tx_pin_i,
  input wire logic serial_tx_pin_o,
  input wire logic serial_tx_pin_oe,
  input wire logic serial_rx_pin_i,
  input wire logic serial_rx_pin_o,
  input wire logic serial_rx_pin_oe,
  input wire logic tx_int,
  input wire logic rx_int
);
  localparam logic [15:0] A_END = ASP_BASE + ASP_NUM_REGS;
  localparam logic [15:0] A_TXB = ASP_BASE + {12'h000, REG_TX_BUF};
  logic [7:0] pin_sh;
  logic [7:0] ctl1_sh;
  logic [7:0] ctl2_sh;
  logic [15:0] baud_sh;
  logic [7:0] low_run;
  logic ser;
  logic fast;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // timing checks only hold at the fastest rate, divisor 0 acts as 1
  assign ser = pin_sh[PC_TX_FUNC];
  assign fast = baud_sh <= 16'h0001;
  // shadows follow writes; the upper byte never matters
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pin_sh <= PIN_CTL_RST;
      ctl1_sh <= CTL1_RST;
      ctl2_sh <= CTL2_RST;
      baud_sh <= BAUD_RST;
    end else if (bus_wr && bus_addr[15:4] == ASP_BASE[15:4]) begin
      case (bus_addr[3:0])
        REG_PIN_CTL: pin_sh <= bus_wdata[7:0];
        REG_CTL1: ctl1_sh <= bus_wdata[7:0];
        REG_CTL2: ctl2_sh <= bus_wdata[7:0];
        REG_BAUD_HI: baud_sh[15:8] <= bus_wdata[7:0];
        REG_BAUD_LO: baud_sh[7:0] <= bus_wdata[7:0];
        default: ;
      endcase
    end
  end
  // low run length on the transmit line, saturating
  always_ff @(posedge core_clk) begin
    if (sys_rst || !ser || serial_tx_pin_o) low_run <= 8'h00;
    else if (low_run != 8'hFF) low_run <= low_run + 8'h01;
  end
  sequence s_tx_load;
    bus_wr && bus_addr == A_TXB && ctl1_sh[C1_TX_EN] && ser && fast;
  endsequence
  sequence s_start_low;
    ##[1:420] !serial_tx_pin_o;
  endsequence
  sequence s_line_rise;
    $rose(serial_tx_pin_o) && ser && fast && ctl1_sh[C1_TX_EN];
  endsequence
  chk_start_follows: assert property (s_tx_load |-> s_start_low)
    else $error("no start bit after a transmit load");
  chk_bit_width: assert property (s_line_rise |-> low_run >= 8'h0E)
    else $error("serial low run shorter than one bit");
  chk_rdata_gap: assert property (
    bus_rdata != 16'h0000 |-> $past(bus_rd))
    else $error("read data outside the answer cycle");
  chk_unmapped: assert property (
    bus_rd && (bus_addr < ASP_BASE || bus_addr >= A_END)
    |=> bus_rdata == 16'h0000)
    else $error("unmapped read returned data");
  chk_upper_zero: assert property (bus_rdata[15:8] == 8'h00)
    else $error("upper read byte not zero");
  chk_tx_serial_oe: assert property (ser |-> serial_tx_pin_oe)
    else $error("serial transmit pin not driven");
  chk_tx_gpio: assert property (
    !ser |-> serial_tx_pin_oe == pin_sh[PC_TX_DIR]
    && (!pin_sh[PC_TX_DIR] || serial_tx_pin_o == pin_sh[PC_TX_OUT]))
    else $error("transmit pin ignores its gpio bits");
  chk_rx_gpio: assert property (
    serial_rx_pin_oe == (!pin_sh[PC_RX_FUNC] && pin_sh[PC_RX_DIR])
    && (!serial_rx_pin_oe || serial_rx_pin_o == pin_sh[PC_RX_OUT]))
    else $error("receive pin ignores its gpio bits");
  chk_tx_int_gate: assert property (
    tx_int |-> ctl2_sh[C2_TX_IE] && ctl1_sh[C1_TX_EN])
    else $error("transmit interrupt without its enables");
  chk_tx_idle_high: assert property (
    ser && !ctl1_sh[C1_TX_EN] |-> serial_tx_pin_o)
    else $error("disabled transmitter not idling high");
endmodule
`default_nettype wire

/* asp_peer.sv */
`timescale 1ns/100ps
`default_nettype none
// remote asynchronous peer, bit period counted in core clocks
module asp_peer #(
  parameter int BIT = 16
) (
  input wire logic core_clk,
  input wire logic line_in,
  output logic line_out
);
  initial line_out = 1'b1; // line idles high
  // sample bit centres timed from the start edge
  task automatic listen(input int n, output logic [31:0] bits);
    bits = 32'h0000_0000;
    @(negedge line_in);
    repeat (BIT / 2) @(posedge core_clk);
    for (int k = 0; k < n; k++) begin
      bits[k] = line_in;
      repeat (BIT) @(posedge core_clk);
    end
  endtask
  // frame bits arrive lsb first, start and stops included
  task automatic send(input int n, input logic [15:0] bits);
    @(posedge core_clk);
    for (int k = 0; k < n; k++) begin
      line_out <= bits[k];
      repeat (BIT) @(posedge core_clk);
    end
    line_out <= 1'b1;
  endtask
endmodule
`default_nettype wire

/* asp_serial_port_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module asp_serial_port_bench;
  import asp_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] bus_addr = 16'h0000;
  logic [15:0] bus_wdata = 16'h0000;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [15:0] bus_rdata;
  logic tx_o, tx_oe, rx_o, rx_oe, tx_int, rx_int, peer_out;
  logic [31:0] got;
  int n_fail = 0;
  int n_tests = 0;
  // pull-up on the transmit line: a released pin reads high; a released receive pin reads the peer
  wire logic tx_wire = tx_oe ? tx_o : 1'b1;
  wire logic rx_wire = rx_oe ? rx_o : peer_out;
  always #25 core_clk = ~core_clk;
  asp_serial_port i_dut (.core_clk, .sys_rst, .bus_addr, .bus_wdata,
    .bus_wr, .bus_rd, .bus_rdata, .serial_tx_pin_i(tx_wire),
    .serial_tx_pin_o(tx_o), .serial_tx_pin_oe(tx_oe),
    .serial_rx_pin_i(rx_wire), .serial_rx_pin_o(rx_o),
    .serial_rx_pin_oe(rx_oe), .tx_int, .rx_int);
  // divisor 1 gives the fastest bit, sixteen clocks
  asp_peer #(.BIT(16)) i_peer (.core_clk, .line_in(tx_wire),
    .line_out(peer_out));

  function automatic logic [15:0] ra(input logic [3:0] i);
    return ASP_BASE + {12'h000, i};
  endfunction
  // expected frame, lsb first; everything above the parity is high
  function automatic logic [15:0] frame(input logic [7:0] d, input int len,
      input logic pe, input logic odd);
    logic [15:0] f;
    logic p;
    f = 16'hFFFE;
    p = odd;
    for (int k = 0; k < len; k++) begin
      f[k + 1] = d[k];
      p ^= d[k];
    end
    if (pe) f[len + 1] = p;
    return f;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // bus cycles; the gap cycle keeps strobes from being reassigned
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge core_clk);
    bus_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] v);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge core_clk);
    bus_rd <= 1'b0;
    #1 v = {16'h0000, bus_rdata};
    @(posedge core_clk);
  endtask
  task automatic rc(input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    check(v, exp);
  endtask
  task automatic t_regs();
    logic [7:0] rst_val [11] = '{8'h07, 8'h00, 8'h00, 8'h00, 8'hC0,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hC3};
    for (int i = 0; i < 11; i++)
      if (i != 6 && i != 7) rc(ra(4'(i)), {24'h0, rst_val[i]});
    wr(ra(REG_BAUD_LO), 16'hFF01);
    rc(ra(REG_BAUD_LO), 32'h01);
    wr(ra(REG_BAUD_HI), 16'h5A00);
    rc(ra(REG_BAUD_HI), 32'h00);
    wr(ASP_BASE + ASP_NUM_REGS, 16'h00FF);
    rc(ASP_BASE + ASP_NUM_REGS, 32'h00);
    rc(ASP_BASE - 16'h0001, 32'h00);
    $display("test regs done");
  endtask
  task automatic t_gpio();
    wr(ra(REG_PIN_CTL), 16'h0034);
    check({28'h0, tx_oe, tx_o, rx_oe, rx_o}, 32'hB);
    rc(ra(REG_PIN_CTL), 32'hB4);
    wr(ra(REG_PIN_CTL), 16'h0000);
    rc(ra(REG_PIN_CTL), 32'hC0);
    wr(ra(REG_PIN_CTL), 16'h0003);
    $display("test gpio done");
  endtask
  // every length, parity mode and stop count, two characters queued
  task automatic t_tx();
    logic [15:0] f1, f2;
    logic [31:0] m, exp;
    logic [7:0] d;
    int n;
    wr(ra(REG_CTL1), 16'h0002);
    wr(ra(REG_CTL2), 16'h0001);
    for (int c = 0; c < 8; c++) begin
      d = 8'h96 + 8'(c);
      n = c + 3 + int'(c[0]) + int'(c[2]);
      wr(ra(REG_CHAR_CTL), {8'h00, c[2], c[1], c[0], 2'b00, c[2:0]});
      f1 = frame(d, c + 1, c[0], c[1]);
      f2 = frame(~d, c + 1, c[0], c[1]);
      m = (32'h1 << n) - 32'h1;
      exp = (({16'h0, f2} & m) << n) | ({16'h0, f1} & m);
      fork
        i_peer.listen(2 * n, got);
        begin
          wr(ra(REG_TX_BUF), {8'h00, d});
          wr(ra(REG_TX_BUF), {8'h00, ~d});
          rc(ra(REG_CTL2), 32'h01);
        end
      join
      check(got, exp);
      repeat (16) @(posedge core_clk);
      rc(ra(REG_CTL2), 32'hC1);
      check({31'h0, tx_int}, 32'h1);
    end
    $display("test transmit done");
  endtask
  task automatic rx_case(input logic [15:0] f, input int reps,
      input logic [7:0] sm, input logic [7:0] se, input logic [7:0] de);
    logic [31:0] v;
    repeat (reps) i_peer.send(11, f);
    repeat (16) @(posedge core_clk);
    rd(ra(REG_RX_STAT), v);
    check(v & {24'h0, sm}, {24'h0, se});
    check({31'h0, rx_int}, 32'h1);
    rd(ra(REG_RX_BUF), v);
    check(v, {24'h0, de});
    // the wake mark outlives the buffer read, the rest is cleared
    rd(ra(REG_RX_STAT), v);
    check(v & 32'hFD, 32'h00);
  endtask
  // eight bits, even parity, one stop; full duplex enables
  task automatic t_rx();
    logic [15:0] good;
    good = frame(8'h3C, 8, 1'b1, 1'b0);
    wr(ra(REG_CHAR_CTL), 16'h0027);
    wr(ra(REG_CTL1), 16'h0043);
    wr(ra(REG_CTL2), 16'h0002);
    check({31'h0, tx_int}, 32'h0);
    // a long idle gap ahead marks the first character as an address
    rx_case(good, 1, 8'hFF, 8'h42, 8'h3C);
    rx_case(good ^ 16'h0200, 1, 8'hFD, 8'hC4, 8'h3C);
    rx_case(good & 16'hFBFF, 1, 8'hFD, 8'hD0, 8'h3C);
    rx_case(good, 2, 8'hFD, 8'hC8, 8'h3C);
    wr(ra(REG_CTL2), 16'h0000);
    wr(ra(REG_CTL1), 16'h0003);
    rx_case(16'h0000, 1, 8'hB0, 8'hB0, 8'h00);
    $display("test receive done");
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    t_regs();
    t_gpio();
    t_tx();
    t_rx();
    stop_test();
  end
  // the whole run needs well under ten thousand cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    $display("Error at %0t: watchdog expired", $time);
    stop_test();
  end
endmodule
bind asp_serial_port asp_serial_port_chk i_chk (.core_clk, .sys_rst,
  .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .serial_tx_pin_i,
  .serial_tx_pin_o, .serial_tx_pin_oe, .serial_rx_pin_i, .serial_rx_pin_o,
  .serial_rx_pin_oe, .tx_int, .rx_int);
`default_nettype wire
